// ==== core/mbi_map.svh ====
/*
 * Constants of the host bus interface: widths, reset values and pipeline depths.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef MBI_MAP_SVH
`define MBI_MAP_SVH

// Width of one address/data byte port.
`define MBI_PORT_W 8
// Width of the address handed to the decode logic.
`define MBI_ADDR_W 20
// Width of the read data offered by the internal blocks.
`define MBI_DATA_W 16
// Reset value of the decode address.
`define MBI_ADDR_RST 20'h00000
// Reset value of a latched address byte.
`define MBI_BYTE_RST 8'h00
// Flip-flop stages of the pin synchroniser.
`define MBI_SYNC_STAGES 2
// Lowest burst address bit carried by the lower byte port.
`define MBI_BURST_LSB 4

`endif

// ==== core/mbi_pkg.sv ====
/*
 * Types shared by the host bus interface modules.
 * Assumes the constant header is on the include path.
 */
package mbi_pkg;
`include "mbi_map.svh"

	// Wiring style of the host address/data bus.
	typedef enum logic [1:0] {
		MBI_BUS_MUX    = 2'h0, // Data shares the low address byte.
		MBI_BUS_NONMUX = 2'h1, // Separate buses, data arrives elsewhere.
		MBI_BUS_PAGE   = 2'h2, // Data shares the high address byte.
		MBI_BUS_BURST  = 2'h3  // Sixteen data bits over address bits 4 to 19.
	} mbi_bus_type;

	// Meaning of the write control input.
	typedef enum logic {
		MBI_WR_STROBE = 1'b0, // Active low write strobe.
		MBI_WR_RW     = 1'b1  // High for read, low for write.
	} mbi_wr_type;

	// Meaning of the read control input.
	typedef enum logic [1:0] {
		MBI_RD_STROBE = 2'h0, // Active low read strobe.
		MBI_RD_ECLK   = 2'h1, // Bus clock, data phase while high.
		MBI_RD_DS     = 2'h2, // Active low data strobe.
		MBI_RD_FETCH  = 2'h3  // Program fetch strobe used as read.
	} mbi_rd_type;

	// Bus cycle phase; Gray coded along idle, address, hold.
	typedef enum logic [1:0] {
		MBI_ST_IDLE = 2'b00,
		MBI_ST_ADDR = 2'b01,
		MBI_ST_HOLD = 2'b11
	} mbi_state_type;

	// Decoded host controls handed to the logic arrays.
	typedef struct packed {
		logic rd;         // Host read in progress.
		logic wr;         // Host write in progress.
		logic code_fetch; // Code fetch strobe active.
		logic gen_in;     // Program select pin as a plain level.
		logic strobe;     // Address strobe level.
	} mbi_ctrl_type;

endpackage : mbi_pkg

// ==== core/mbi_sync.sv ====
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes each bit is a level that is held for several clock periods.
 */
`timescale 1ns/100ps
module mbi_sync
	import mbi_pkg::*;
#(
	parameter int          W       = 1,      // Number of bits.
	parameter logic [W-1:0] RST_VAL = '0     // Idle level of each pin.
) (
	input  wire logic         clk,  // System clock.
	input  wire logic         rst,  // Asynchronous reset, active high.
	input  wire logic [W-1:0] d,    // Pin levels from outside.
	output logic      [W-1:0] q     // Levels safe to use.
);

	logic [W-1:0] meta_q; // First stage, read only by the second.

	// Both stages reset to the idle level so that no false strobe appears.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : mbi_sync

// ==== core/mbi_host_port.sv ====
/*
 * Host bus interface of the programmable peripheral: address capture,
 * control decoding for the logic arrays and read data drive.
 * Assumes decode logic on the same clock returns block_select and read_data,
 * and that the host strobes are slow against the 20 MHz clock.
 */
// Behaviour
// - Strobe latches address, held for the cycle.
// - Drive data only on read and selection.
// - Forward address to the decode logic.
// - Mux host: low data shared, high address.
// - Nonmux host: both ports carry address.
// - Page host: low address, high data shared.
// - Burst host: address 4-19 shared with data.
// - Write input: strobe or read/write level.
// - Read input: strobe, clock, data strobe, fetch.
// - All controls reach the logic arrays.
// - Program select: code fetch or plain input.
// - Reset pin clears ports, arrays, configuration; here the style and fetch select inputs are not cleared.
`timescale 1ns/100ps
`include "mbi_map.svh"
module mbi_host_port
	import mbi_pkg::*;
(
	input  wire logic                   clk,                   // 20 MHz clock.
	input  wire logic                   rst,                   // Async reset, high.
	input  wire logic [`MBI_PORT_W-1:0] lower_addr_data_port_in, // Lower port level.
	output logic      [`MBI_PORT_W-1:0] lower_addr_data_port_out, // Lower port data.
	output logic                        lower_addr_data_port_oe, // Lower port drive.
	input  wire logic [`MBI_PORT_W-1:0] upper_addr_data_port_in, // Upper port level.
	output logic      [`MBI_PORT_W-1:0] upper_addr_data_port_out, // Upper port data.
	output logic                        upper_addr_data_port_oe, // Upper port drive.
	input  wire logic                   write_control_input,   // Write pin.
	input  wire logic                   read_control_input,    // Read pin.
	input  wire logic                   program_select_input,  // Program select pin.
	input  wire logic                   address_strobe_in,     // Address strobe, high.
	input  wire logic                   reset_pin_n,           // Reset pin, low.
	input  wire mbi_bus_type            bus_style,             // Host bus wiring.
	input  wire mbi_wr_type             wr_style,              // Write pin meaning.
	input  wire mbi_rd_type             rd_style,              // Read pin meaning.
	input  wire logic                   fetch_on_select,       // Select pin is fetch.
	input  wire logic                   block_select,          // Decoded hit.
	input  wire logic [`MBI_DATA_W-1:0] read_data,             // Data of the hit.
	output logic      [`MBI_ADDR_W-1:0] decode_addr_q,         // Address to decode.
	output mbi_ctrl_type                ctrl_q,                // Controls to arrays.
	output logic                        port_reset_q           // Reset to ports.
);

	logic [`MBI_PORT_W-1:0] lo_s;     // Synchronised lower port.
	logic [`MBI_PORT_W-1:0] hi_s;     // Synchronised upper port.
	logic                   w_s;      // Synchronised write pin.
	logic                   r_s;      // Synchronised read pin.
	logic                   ps_s;     // Synchronised select pin.
	logic                   as_s;     // Synchronised address strobe.
	logic                   rstn_s;   // Synchronised reset pin.
	logic [`MBI_PORT_W-1:0] lat_lo_q; // Latched lower address byte.
	logic [`MBI_PORT_W-1:0] lat_hi_q; // Latched upper address byte.
	mbi_state_type          st_q;     // Bus cycle phase.
	mbi_state_type          st_d;     // Next bus cycle phase.
	logic                   phase_on; // Data phase of clocked or strobed buses.
	logic                   host_rd;  // Host read from the read and write pins.
	logic                   host_wr;  // Host write.
	logic                   fetch;    // Code fetch from the select pin.
	logic                   rd_act;   // Any read that may be answered.
	logic [`MBI_ADDR_W-1:0] addr_d;   // Assembled address.

	// Control pins idle high except the address strobe, which is active high; the byte ports start low.
	// The idle pattern keeps a false read or strobe out of the first edges after reset.
	mbi_sync #(
		.W       (2 * `MBI_PORT_W + 5),
		.RST_VAL ({{(2 * `MBI_PORT_W){1'b0}}, 5'h1d})
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({lower_addr_data_port_in, upper_addr_data_port_in, write_control_input,
		        read_control_input, program_select_input, address_strobe_in,
		        reset_pin_n}),
		.q   ({lo_s, hi_s, w_s, r_s, ps_s, as_s, rstn_s})
	);

	// Whether a bus style puts read data on the lower byte port.
	function automatic logic drives_lower(input mbi_bus_type s);
		drives_lower = (s == MBI_BUS_MUX) || (s == MBI_BUS_BURST);
	endfunction : drives_lower

	// Whether a bus style puts read data on the upper byte port.
	function automatic logic drives_upper(input mbi_bus_type s);
		drives_upper = (s == MBI_BUS_PAGE) || (s == MBI_BUS_BURST);
	endfunction : drives_upper

	// Decode the control pins according to the host type.
	always_comb begin
		// A bus clock marks the data phase while high, a data strobe while low.
		phase_on = (rd_style == MBI_RD_ECLK) ? r_s : !r_s;
		if (wr_style == MBI_WR_RW) begin
			// Direction level: reads and writes only count in the data phase.
			host_rd = w_s && phase_on;
			host_wr = !w_s && phase_on;
		end else begin
			// Separate strobes: the write pin is an active low strobe, the read pin too unless it is a bus clock.
			host_rd = (rd_style == MBI_RD_ECLK) ? r_s : !r_s;
			host_wr = !w_s;
		end
		fetch  = fetch_on_select && !ps_s;
		rd_act = host_rd || fetch;
	end

	// Assemble the address for each wiring style.
	always_comb begin
		case (bus_style)
			MBI_BUS_MUX: begin
				addr_d = {4'h0, hi_s, lat_lo_q};
			end
			MBI_BUS_NONMUX: begin
				addr_d = {4'h0, hi_s, lo_s};
			end
			MBI_BUS_PAGE: begin
				addr_d = {4'h0, lat_hi_q, lo_s};
			end
			MBI_BUS_BURST: begin
				// Bits 0 to 3 arrive on another port and are not seen here.
				addr_d = {lat_hi_q, lat_lo_q, {`MBI_BURST_LSB{1'b0}}};
			end
			default: begin
				addr_d = `MBI_ADDR_RST;
			end
		endcase
	end

	// Bus cycle phase: the address is open while the strobe is high, then held.
	always_comb begin
		case (st_q)
			MBI_ST_IDLE: begin
				st_d = as_s ? MBI_ST_ADDR : MBI_ST_IDLE;
			end
			MBI_ST_ADDR: begin
				st_d = as_s ? MBI_ST_ADDR : MBI_ST_HOLD;
			end
			MBI_ST_HOLD: begin
				st_d = as_s ? MBI_ST_ADDR : MBI_ST_HOLD;
			end
			default: begin
				st_d = MBI_ST_IDLE;
			end
		endcase
	end

	// Phase register; the reset pin returns it to idle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= MBI_ST_IDLE;
		end else if (!rstn_s) begin
			st_q <= MBI_ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Address latch follows the ports while the strobe is high and freezes on its fall.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lat_lo_q <= `MBI_BYTE_RST;
			lat_hi_q <= `MBI_BYTE_RST;
		end else if (!rstn_s) begin
			lat_lo_q <= `MBI_BYTE_RST;
			lat_hi_q <= `MBI_BYTE_RST;
		end else if (as_s) begin
			lat_lo_q <= lo_s;
			lat_hi_q <= hi_s;
		end
	end

	// Address and controls to the decode logic and arrays, one cycle late.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			decode_addr_q <= `MBI_ADDR_RST;
			ctrl_q        <= '0;
		end else if (!rstn_s) begin
			decode_addr_q <= `MBI_ADDR_RST;
			ctrl_q        <= '0;
		end else begin
			decode_addr_q     <= addr_d;
			ctrl_q.rd         <= rd_act;
			ctrl_q.wr         <= host_wr;
			ctrl_q.code_fetch <= fetch;
			ctrl_q.gen_in     <= ps_s;
			ctrl_q.strobe     <= as_s;
		end
	end

	// Read data drive. Holding data in flops costs a cycle of latency but keeps
	// pin drivers glitch free while the select settles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lower_addr_data_port_out <= `MBI_BYTE_RST;
			upper_addr_data_port_out <= `MBI_BYTE_RST;
			lower_addr_data_port_oe  <= 1'b0;
			upper_addr_data_port_oe  <= 1'b0;
		end else if (!rstn_s || !(rd_act && block_select)) begin
			lower_addr_data_port_oe <= 1'b0;
			upper_addr_data_port_oe <= 1'b0;
		end else begin
			lower_addr_data_port_oe  <= drives_lower(bus_style);
			upper_addr_data_port_oe  <= drives_upper(bus_style);
			lower_addr_data_port_out <= read_data[7:0];
			// Page mode carries its byte on the upper port, burst its high byte.
			upper_addr_data_port_out <= (bus_style == MBI_BUS_PAGE) ?
				read_data[7:0] : read_data[15:8];
		end
	end

	// Reset handed on to the ports and macrocells while the pin is low.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_reset_q <= 1'b1;
		end else begin
			port_reset_q <= !rstn_s;
		end
	end

	// Checks on the behaviour above.
	a_addr_held: assert property (@(posedge clk) disable iff (rst)
		(st_q == MBI_ST_HOLD && $past(st_q) == MBI_ST_HOLD) |-> $stable(lat_lo_q))
		else $error("Latched address moved during the hold phase.");
	a_drive_cause: assert property (@(posedge clk) disable iff (rst)
		(lower_addr_data_port_oe || upper_addr_data_port_oe) |->
		$past(rd_act && block_select && rstn_s))
		else $error("Port driven without a selected read.");
	a_float_idle: assert property (@(posedge clk) disable iff (rst)
		!rd_act ##1 1'b1 |-> !lower_addr_data_port_oe && !upper_addr_data_port_oe)
		else $error("Port driven outside a read.");
	a_mux_map: assert property (@(posedge clk) disable iff (rst)
		(bus_style == MBI_BUS_MUX && rstn_s) |=>
		decode_addr_q[15:0] == {$past(hi_s), $past(lat_lo_q)})
		else $error("Multiplexed address assembled wrongly.");
	a_nonmux_map: assert property (@(posedge clk) disable iff (rst)
		(bus_style == MBI_BUS_NONMUX && rstn_s) |=>
		decode_addr_q[15:0] == {$past(hi_s), $past(lo_s)})
		else $error("Plain address assembled wrongly.");
	a_page_map: assert property (@(posedge clk) disable iff (rst)
		(bus_style == MBI_BUS_PAGE && rstn_s) |=>
		decode_addr_q[15:0] == {$past(lat_hi_q), $past(lo_s)})
		else $error("Page address assembled wrongly.");
	a_burst_map: assert property (@(posedge clk) disable iff (rst)
		(bus_style == MBI_BUS_BURST && rstn_s) |=>
		decode_addr_q[19:4] == {$past(lat_hi_q), $past(lat_lo_q)})
		else $error("Burst address assembled wrongly.");
	a_write_strobe: assert property (@(posedge clk) disable iff (rst)
		(wr_style == MBI_WR_STROBE && !w_s && rstn_s) |=> ctrl_q.wr)
		else $error("Write strobe not seen.");
	a_read_strobe: assert property (@(posedge clk) disable iff (rst)
		(wr_style == MBI_WR_STROBE && rd_style == MBI_RD_STROBE && !r_s && rstn_s)
		|=> ctrl_q.rd)
		else $error("Read strobe not seen.");
	a_fetch_sel: assert property (@(posedge clk) disable iff (rst)
		(fetch_on_select && !ps_s && rstn_s) |=> ctrl_q.code_fetch && ctrl_q.rd)
		else $error("Code fetch not seen.");
	a_pin_reset: assert property (@(posedge clk) disable iff (rst)
		!rstn_s |=> port_reset_q && decode_addr_q == `MBI_ADDR_RST && !ctrl_q.wr)
		else $error("Reset pin did not clear the outputs.");

	c_read_drive: cover property (@(posedge clk) disable iff (rst)
		lower_addr_data_port_oe && upper_addr_data_port_oe);
	c_write_seen: cover property (@(posedge clk) disable iff (rst) ctrl_q.wr);
	c_hold_entry: cover property (@(posedge clk) disable iff (rst)
		st_q == MBI_ST_ADDR ##1 st_q == MBI_ST_HOLD);

endmodule : mbi_host_port

// ==== test/mbi_host_model.sv ====
/*
 * Behavioural host microcontroller driving the byte ports and control pins.
 * Assumes the device port data and enables are fed back to resolve the bus.
 */
`timescale 1ns/100ps
module mbi_host_model
	import mbi_pkg::*;
(
	input  wire logic       clk,      // System clock.
	input  wire logic [7:0] lo_out,   // Device lower port data.
	input  wire logic       lo_oe,    // Device lower port drive.
	input  wire logic [7:0] up_out,   // Device upper port data.
	input  wire logic       up_oe,    // Device upper port drive.
	output logic      [7:0] lo_pin,   // Resolved lower port level.
	output logic      [7:0] up_pin,   // Resolved upper port level.
	output logic            as_pin,   // Address strobe, high.
	output logic            rd_pin,   // Read control pin.
	output logic            wr_pin,   // Write control pin.
	output logic            sel_pin,  // Program select pin.
	output logic            rst_pin_n // Device reset pin, low.
);
	logic [7:0] lo_q; // Host lower byte.
	logic [7:0] up_q; // Host upper byte.
	logic       en_q; // Host drives both bytes.

	// A floating bus shows the inverse of the last value, so stale data never matches.
	assign lo_pin = lo_oe ? lo_out : (en_q ? lo_q : ~lo_q);
	assign up_pin = up_oe ? up_out : (en_q ? up_q : ~up_q);

	// Power-up state: bus idle, strobes inactive, device held in reset.
	initial begin
		lo_q = 8'h00;
		up_q = 8'h00;
		en_q = 1'b1;
		as_pin = 1'b0;
		rd_pin = 1'b1;
		wr_pin = 1'b1;
		sel_pin = 1'b1;
		rst_pin_n = 1'b0;
	end

	// Sets all pins but the reset pin at a falling edge and holds them four clocks, above the three needed.
	task put(input logic [7:0] lo, input logic [7:0] up, input logic en, input logic as_v,
		input logic rd, input logic wr, input logic sel);
		@(negedge clk);
		lo_q = lo;
		up_q = up;
		en_q = en;
		as_pin = as_v;
		rd_pin = rd;
		wr_pin = wr;
		sel_pin = sel;
		repeat (4) @(negedge clk);
	endtask : put

	// Moves the reset pin at a falling edge.
	task set_reset(input logic v);
		@(negedge clk);
		rst_pin_n = v;
	endtask : set_reset
endmodule : mbi_host_model

// ==== test/tb.sv ====
/*
 * Self-checking bench of the host bus interface with a host model.
 * Assumes the two-stage pin synchroniser and the output registers answer three edges after a pin change.
 */
`timescale 1ns/100ps
module tb;
	import mbi_pkg::*;
	logic         clk, rst, lo_oe, up_oe, as_pin, rd_pin, wr_pin, sel_pin, rst_pin_n;
	logic   [7:0] lo_pin, up_pin, lo_out, up_out;
	mbi_bus_type  bus_style;    // Host wiring.
	mbi_wr_type   wr_style;     // Write pin meaning.
	mbi_rd_type   rd_style;     // Read pin meaning.
	logic         fetch_on_select, block_select, port_reset_q;
	logic  [15:0] read_data;    // Data of the selected block.
	logic  [19:0] decode_addr_q; // Address to decode.
	mbi_ctrl_type ctrl_q;       // Controls to the arrays.
	int           bad_count, checked, cycles;

	mbi_host_port u_dut(.clk(clk), .rst(rst), .lower_addr_data_port_in(lo_pin),
		.lower_addr_data_port_out(lo_out), .lower_addr_data_port_oe(lo_oe),
		.upper_addr_data_port_in(up_pin), .upper_addr_data_port_out(up_out),
		.upper_addr_data_port_oe(up_oe), .write_control_input(wr_pin),
		.read_control_input(rd_pin), .program_select_input(sel_pin),
		.address_strobe_in(as_pin), .reset_pin_n(rst_pin_n), .bus_style(bus_style),
		.wr_style(wr_style), .rd_style(rd_style), .fetch_on_select(fetch_on_select),
		.block_select(block_select), .read_data(read_data), .decode_addr_q(decode_addr_q),
		.ctrl_q(ctrl_q), .port_reset_q(port_reset_q));
	mbi_host_model u_host(.clk(clk), .lo_out(lo_out), .lo_oe(lo_oe), .up_out(up_out),
		.up_oe(up_oe), .lo_pin(lo_pin), .up_pin(up_pin), .as_pin(as_pin), .rd_pin(rd_pin),
		.wr_pin(wr_pin), .sel_pin(sel_pin), .rst_pin_n(rst_pin_n));

	// Clock of 50 ns period.
	always #25 clk = ~clk;

	// Compares one value and counts it.
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// Latches 3c/c5, then changes both bytes and checks which ones the address keeps.
	task automatic t_addr();
		logic [19:0] exp;
		for (int s = 0; s < 4; s++) begin
			@(negedge clk);
			bus_style = mbi_bus_type'(s);
			u_host.put(8'h3c, 8'hc5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
			chk({19'h0, ctrl_q.strobe}, 20'h1);
			u_host.put(8'h3c, 8'hc5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
			u_host.put(8'h96, 8'h69, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
			case (s)
				0: exp = {4'h0, 8'h69, 8'h3c};
				1: exp = {4'h0, 8'h69, 8'h96};
				2: exp = {4'h0, 8'hc5, 8'h96};
				default: exp = {8'hc5, 8'h3c, 4'h0};
			endcase
			chk(decode_addr_q, exp);
		end
		$display("address test done");
	endtask : t_addr

	// Reads 5aa5 in every style, then drops the selection and the read.
	task automatic t_read();
		logic [19:0] exp;
		for (int s = 0; s < 4; s++) begin
			@(negedge clk);
			bus_style = mbi_bus_type'(s);
			block_select = 1'b1;
			read_data = 16'h5aa5;
			u_host.put(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
			case (s)
				0: exp = {4'h2, 8'ha5, 8'h00};
				1: exp = {4'h0, 8'h00, 8'h00};
				2: exp = {4'h1, 8'h00, 8'ha5};
				default: exp = {4'h3, 8'ha5, 8'h5a};
			endcase
			chk({2'h0, lo_oe, up_oe, lo_oe ? lo_out : 8'h00, up_oe ? up_out : 8'h00}, exp);
			block_select = 1'b0;
			u_host.put(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
			chk({18'h0, lo_oe, up_oe}, 20'h0);
			block_select = 1'b1;
			u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
			chk({18'h0, lo_oe, up_oe}, 20'h0);
		end
		$display("read test done");
	endtask : t_read

	// Decodes every read pin meaning, both write meanings and the select pin.
	task automatic t_ctrl();
		for (int r = 0; r < 4; r++) begin
			@(negedge clk);
			rd_style = mbi_rd_type'(r);
			wr_style = MBI_WR_STROBE;
			u_host.put(8'h00, 8'h00, 1'b1, 1'b0, r == 1, 1'b1, 1'b1);
			chk({15'h0, ctrl_q}, {15'h0, 5'h12});
		end
		@(negedge clk);
		rd_style = MBI_RD_STROBE;
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		chk({15'h0, ctrl_q}, {15'h0, 5'h0a});
		wr_style = MBI_WR_RW;
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		chk({15'h0, ctrl_q}, {15'h0, 5'h0a});
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		chk({15'h0, ctrl_q}, {15'h0, 5'h12});
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		chk({15'h0, ctrl_q}, {15'h0, 5'h02});
		rd_style = MBI_RD_ECLK;
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		chk({15'h0, ctrl_q}, {15'h0, 5'h0a});
		rd_style = MBI_RD_STROBE;
		wr_style = MBI_WR_STROBE;
		fetch_on_select = 1'b1;
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		chk({15'h0, ctrl_q}, {15'h0, 5'h14});
		fetch_on_select = 1'b0;
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		chk({15'h0, ctrl_q}, {15'h0, 5'h00});
		$display("control test done");
	endtask : t_ctrl

	// Pulls the reset pin in the middle of a selected read.
	task automatic t_reset();
		@(negedge clk);
		bus_style = MBI_BUS_MUX;
		block_select = 1'b1;
		u_host.put(8'h11, 8'h22, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		u_host.put(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		chk({19'h0, lo_oe}, 20'h1);
		u_host.set_reset(1'b0);
		repeat (4) @(negedge clk);
		chk({18'h0, port_reset_q, lo_oe}, 20'h2);
		chk(decode_addr_q, 20'h0);
		u_host.set_reset(1'b1);
		u_host.put(8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		chk({19'h0, port_reset_q}, 20'h0);
		$display("reset test done");
	endtask : t_reset

	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			give_verdict();
		end
	end

	// Main sequence: reset for three clocks, release the pin, run the tests.
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		bus_style = MBI_BUS_MUX;
		wr_style = MBI_WR_STROBE;
		rd_style = MBI_RD_STROBE;
		fetch_on_select = 1'b0;
		block_select = 1'b0;
		read_data = 16'h0000;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		u_host.set_reset(1'b1);
		t_addr();
		t_read();
		t_ctrl();
		t_reset();
		give_verdict();
	end
endmodule : tb
